// ### vmeic_unit.sv
// interrupt generation, handling and interprocessor unit of a vme controller
// assumes inputs synchronous to clk, avalon-mm master with waitrequest
//
// Summary of operation
// - seven-level prioritised arbitration of all sources
// - sources: 7 vme, 7 local, error/status, 8 ipc
// - handle any selection of vme request levels
// - raise vme requests, return programmed status/id vector
// - vme interrupt local level is programmable
// - system controller drives acknowledge daisy chain
// - local inputs: programmable level, optional own vector
// - local inputs edge/level, selectable polarity
// - interrupt on dma done, arbitration timeout, interrupter
// - vme switch set raises local interrupt
// - only ipc registers reachable from vmebus
// - four 8-bit general purpose ipc registers
// - four module and four global switches
// - read-only version and reset/halt indication
// - semaphores guarding the ipc registers
//
// The Avalon-MM interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "vmeic_defines.svh"
module vmeic_unit #(
	parameter logic [7:0] VERSION = 8'h01 // arbitrary value
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic irq,
	output logic [2:0] local_priority_level,
	input wire logic [6:0] lirq_in,
	input wire logic [6:0] vme_irq_i,
	output logic [6:0] vme_irq_o,
	output logic [6:0] vme_irq_oe,
	input wire logic vme_iack_n,
	input wire logic vme_iackin_n,
	input wire logic [2:0] vme_ack_level,
	output logic vme_iackout_n,
	output logic daisy_start_n,
	output vmeic_pkg::vmeic_vec_s vme_vec,
	input wire logic acfail_n,
	input wire logic sysfail_n,
	input wire logic wpost_berr,
	input wire logic dma_done,
	input wire logic arb_timeout,
	input wire logic reset_cond,
	input wire logic halt_cond,
	input wire vmeic_pkg::vmeic_ipc_req_s ipc_req,
	output logic [7:0] ipc_rdata
);
	import vmeic_pkg::*;

	localparam int NS = `VMEIC_NSRC;

	// ------------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------------
	logic sysctl, next_sysctl;
	logic [6:0] hnd_en, next_hnd_en;
	logic [20:0] vme_lvl, next_vme_lvl;
	logic [20:0] lirq_lvl, next_lirq_lvl;
	logic [22:0] lirq_cfg, next_lirq_cfg;
	logic [6:0] grp_lvl, next_grp_lvl;
	logic [27:0] status, next_status;
	logic [27:0] mask, next_mask;
	logic [6:0] intr_req, next_intr_req;
	logic [7:0] intr_vec, next_intr_vec;
	logic [7:0] vec_base, next_vec_base;
	logic [31:0] ipc_gp, next_ipc_gp;
	logic [3:0] msw, next_msw;
	logic [3:0] gsw, next_gsw;
	logic [3:0] sem, next_sem;
	logic [6:0] lirq_prev, acf_sys_prev;
	logic [27:0] rd_snap, next_rd_snap;
	logic [31:0] next_readdata;
	logic next_waitrequest, next_irq, next_iackout_n, next_daisy_n;
	logic [2:0] next_lpl;
	logic [7:0] next_ipc_rdata;
	vmeic_vec_s next_vec;
	logic [4:0] win_src, next_win_src;
	logic [2:0] win_lvl;

	// ------------------------------------------------------------------------
	// event detection
	// ------------------------------------------------------------------------
	logic [6:0] lirq_act, lirq_pol, lirq_edge;
	logic [27:0] ev;
	logic intr_ev, acc, rd_acc, wr_acc;
	logic [31:0] wmask;
	logic [2:0] src_lvl [NS];

	// bus strobes: a request takes effect at the edge with waitrequest low
	assign acc = (avs_read | avs_write) & ~avs_waitrequest;
	assign rd_acc = avs_read & ~avs_waitrequest;
	assign wr_acc = avs_write & ~avs_waitrequest;
	assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	assign lirq_edge = lirq_cfg[6:0];
	assign lirq_pol = lirq_cfg[14:8];

	// local input conditioning and event vector
	always_comb begin
		for (int i = 0; i < 7; i++) begin
			if (lirq_edge[i]) begin
				lirq_act[i] = lirq_pol[i] ? (lirq_in[i] & ~lirq_prev[i])
					: (~lirq_in[i] & lirq_prev[i]);
			end else begin
				lirq_act[i] = lirq_pol[i] ? lirq_in[i] : ~lirq_in[i];
			end
		end
		intr_ev = ~vme_iack_n & ~vme_iackin_n & (vme_ack_level != 3'd0)
			& intr_req[vme_ack_level - 3'd1];
		ev = '0;
		ev[`VMEIC_ST_VME +: 7] = vme_irq_i & hnd_en;
		ev[`VMEIC_ST_LOC +: 7] = lirq_act;
		// falling edges of the failure lines
		ev[`VMEIC_ST_ERR + `VMEIC_ERR_ACFAIL] = acf_sys_prev[0] & ~acfail_n;
		ev[`VMEIC_ST_ERR + `VMEIC_ERR_SYSFAIL] = acf_sys_prev[1] & ~sysfail_n;
		ev[`VMEIC_ST_ERR + `VMEIC_ERR_WPOST] = wpost_berr;
		ev[`VMEIC_ST_ERR + `VMEIC_ERR_DMA] = dma_done;
		ev[`VMEIC_ST_ERR + `VMEIC_ERR_ARB] = arb_timeout;
		ev[`VMEIC_ST_ERR + `VMEIC_ERR_INTR] = intr_ev;
		// switch set from the vmebus side
		ev[`VMEIC_ST_IPC +: 4] = (ipc_req.wr && ipc_req.addr == `VMEIC_IPC_MSW)
			? ipc_req.wdata[3:0] & ~msw : 4'h0;
		ev[`VMEIC_ST_IPC + 4 +: 4] =
			(ipc_req.wr && ipc_req.addr == `VMEIC_IPC_GSW)
			? ipc_req.wdata[3:0] & ~gsw : 4'h0;
	end

	// ------------------------------------------------------------------------
	// priority arbitration
	// ------------------------------------------------------------------------
	// per-source local level, then the highest pending unmasked one wins
	always_comb begin
		for (int i = 0; i < 7; i++) begin
			src_lvl[i] = vme_lvl[3*i +: 3];
			src_lvl[7+i] = lirq_lvl[3*i +: 3];
		end
		for (int i = 14; i < 20; i++) begin
			src_lvl[i] = grp_lvl[2:0];
		end
		for (int i = 20; i < NS; i++) begin
			src_lvl[i] = grp_lvl[6:4];
		end
		win_lvl = 3'd0;
		next_win_src = 5'd0;
		for (int i = 0; i < NS; i++) begin
			if (status[i] && mask[i] && src_lvl[i] > win_lvl) begin
				win_lvl = src_lvl[i];
				next_win_src = 5'(i);
			end
		end
		next_lpl = win_lvl;
		next_irq = |(status & mask);
	end

	// ------------------------------------------------------------------------
	// local register file
	// ------------------------------------------------------------------------
	// avalon slave with one wait cycle; status read clears what it showed
	always_comb begin
		next_sysctl = sysctl;
		next_hnd_en = hnd_en;
		next_vme_lvl = vme_lvl;
		next_lirq_lvl = lirq_lvl;
		next_lirq_cfg = lirq_cfg;
		next_grp_lvl = grp_lvl;
		next_mask = mask;
		next_intr_req = intr_req;
		next_intr_vec = intr_vec;
		next_vec_base = vec_base;
		next_ipc_gp = ipc_gp;
		next_msw = msw;
		next_gsw = gsw;
		next_sem = sem;
		next_readdata = avs_readdata;
		next_rd_snap = rd_snap;
		next_waitrequest = ~((avs_read | avs_write) & avs_waitrequest);
		if ((avs_read | avs_write) & avs_waitrequest) begin
			next_readdata = 32'h0000_0000;
			next_rd_snap = 28'h000_0000;
			unique case (avs_address)
			`VMEIC_OFS_CTRL: next_readdata[0] = sysctl;
			`VMEIC_OFS_HND_EN: next_readdata[6:0] = hnd_en;
			`VMEIC_OFS_VME_LVL: next_readdata[20:0] = vme_lvl;
			`VMEIC_OFS_LIRQ_LVL: next_readdata[20:0] = lirq_lvl;
			`VMEIC_OFS_LIRQ_CFG: next_readdata[22:0] = lirq_cfg;
			`VMEIC_OFS_GRP_LVL: next_readdata[6:0] = grp_lvl;
			`VMEIC_OFS_STATUS: begin
				next_readdata[27:0] = status;
				next_rd_snap = avs_read ? status : 28'h000_0000;
			end
			`VMEIC_OFS_MASK: next_readdata[27:0] = mask;
			`VMEIC_OFS_INTR: next_readdata[15:0] = {intr_vec, 1'b0, intr_req};
			`VMEIC_OFS_ACK: begin
				// device supplies vector for own sources or opted local ones
				next_readdata[7:0] = vec_base + 8'(win_src);
				next_readdata[10:8] = local_priority_level;
				next_readdata[16] = (win_src >= 5'd14) || (win_src >= 5'd7
					&& lirq_cfg[16 + 32'(win_src) - 7]);
			end
			`VMEIC_OFS_VEC_BASE: next_readdata[7:0] = vec_base;
			`VMEIC_OFS_IPC_GP: next_readdata = ipc_gp;
			`VMEIC_OFS_IPC_SW: next_readdata[11:0] = {sem, gsw, msw};
			default: next_readdata = 32'h0000_0000;
			endcase
		end
		if (wr_acc) begin
			unique case (avs_address)
			`VMEIC_OFS_CTRL: if (avs_byteenable[0]) next_sysctl = avs_writedata[0];
			`VMEIC_OFS_HND_EN:
				next_hnd_en = wr7(hnd_en, avs_writedata[6:0]);
			`VMEIC_OFS_VME_LVL:
				next_vme_lvl = 21'((vme_lvl & ~wmask) | (avs_writedata & wmask));
			`VMEIC_OFS_LIRQ_LVL:
				next_lirq_lvl = 21'((lirq_lvl & ~wmask) | (avs_writedata & wmask));
			`VMEIC_OFS_LIRQ_CFG:
				next_lirq_cfg = 23'((lirq_cfg & ~wmask) | (avs_writedata & wmask));
			`VMEIC_OFS_GRP_LVL: next_grp_lvl = wr7(grp_lvl, avs_writedata[6:0]);
			`VMEIC_OFS_MASK:
				next_mask = 28'((mask & ~wmask) | (avs_writedata & wmask));
			`VMEIC_OFS_INTR: begin
				if (avs_byteenable[0]) next_intr_req = avs_writedata[6:0];
				if (avs_byteenable[1]) next_intr_vec = avs_writedata[15:8];
			end
			`VMEIC_OFS_VEC_BASE:
				if (avs_byteenable[0]) next_vec_base = avs_writedata[7:0];
			`VMEIC_OFS_IPC_GP:
				next_ipc_gp = (ipc_gp & ~wmask) | (avs_writedata & wmask);
			`VMEIC_OFS_IPC_SW: begin
				// local side clears switches and semaphores by writing ones
				if (avs_byteenable[0]) next_msw = msw & ~avs_writedata[3:0];
				if (avs_byteenable[0]) next_gsw = gsw & ~avs_writedata[7:4];
				if (avs_byteenable[1]) next_sem = sem & ~avs_writedata[11:8];
			end
			default: ;
			endcase
		end
		// interrupter request withdrawn once its level is acknowledged
		if (intr_ev) begin
			next_intr_req[vme_ack_level - 3'd1] = 1'b0;
		end
		// vmebus side reaches only the ipc facility
		if (ipc_req.wr) begin
			unique casez (ipc_req.addr)
			4'b00??: next_ipc_gp[8*ipc_req.addr[1:0] +: 8] = ipc_req.wdata;
			`VMEIC_IPC_MSW: next_msw = msw | ipc_req.wdata[3:0];
			`VMEIC_IPC_GSW: next_gsw = gsw | ipc_req.wdata[3:0];
			4'b10??: next_sem[ipc_req.addr[1:0]] = 1'b0;
			default: ;
			endcase
		end else if (ipc_req.rd && ipc_req.addr[3:2] == 2'b10) begin
			next_sem[ipc_req.addr[1:0]] = 1'b1;
		end
		next_status = (status & ~(rd_acc ? rd_snap : 28'h000_0000)) | ev;
	end

	// byte-lane write of a seven-bit field
	function automatic logic [6:0] wr7(input logic [6:0] old,
		input logic [6:0] nv);
		wr7 = avs_byteenable[0] ? nv : old;
	endfunction

	// ------------------------------------------------------------------------
	// vmebus side outputs
	// ------------------------------------------------------------------------
	// ipc read data, interrupter vector, daisy chain
	always_comb begin
		unique casez (ipc_req.addr)
		4'b00??: next_ipc_rdata = ipc_gp[8*ipc_req.addr[1:0] +: 8];
		`VMEIC_IPC_MSW: next_ipc_rdata = {4'h0, msw};
		`VMEIC_IPC_GSW: next_ipc_rdata = {4'h0, gsw};
		`VMEIC_IPC_VER: next_ipc_rdata = VERSION;
		`VMEIC_IPC_RSTHLT: next_ipc_rdata = {6'h00, halt_cond, reset_cond};
		4'b10??: next_ipc_rdata = {7'h00, sem[ipc_req.addr[1:0]]};
		default: next_ipc_rdata = 8'h00;
		endcase
		next_vec.valid = intr_ev;
		next_vec.vector = intr_ev ? intr_vec : 8'h00;
		// pass the acknowledge on when it is not ours
		next_iackout_n = vme_iackin_n | intr_ev;
		next_daisy_n = sysctl ? vme_iack_n : 1'b1;
	end

	// ------------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sysctl <= 1'b0;
			hnd_en <= 7'h00;
			vme_lvl <= 21'h00_0000;
			lirq_lvl <= 21'h00_0000;
			lirq_cfg <= 23'h00_0000;
			grp_lvl <= 7'h00;
			status <= 28'h000_0000;
			mask <= 28'h000_0000;
			intr_req <= 7'h00;
			intr_vec <= `VMEIC_RST_BYTE;
			vec_base <= `VMEIC_RST_BYTE;
			ipc_gp <= `VMEIC_RST_WORD;
			msw <= 4'h0;
			gsw <= 4'h0;
			sem <= 4'h0;
			lirq_prev <= 7'h00;
			acf_sys_prev <= 7'h7F;
			rd_snap <= 28'h000_0000;
			win_src <= 5'h00;
			avs_readdata <= `VMEIC_RST_WORD;
			avs_waitrequest <= 1'b1;
			irq <= 1'b0;
			local_priority_level <= 3'h0;
			vme_irq_o <= 7'h00;
			vme_irq_oe <= 7'h00;
			vme_iackout_n <= 1'b1;
			daisy_start_n <= 1'b1;
			vme_vec <= '0;
			ipc_rdata <= 8'h00;
		end else begin
			sysctl <= next_sysctl;
			hnd_en <= next_hnd_en;
			vme_lvl <= next_vme_lvl;
			lirq_lvl <= next_lirq_lvl;
			lirq_cfg <= next_lirq_cfg;
			grp_lvl <= next_grp_lvl;
			status <= next_status;
			mask <= next_mask;
			intr_req <= next_intr_req;
			intr_vec <= next_intr_vec;
			vec_base <= next_vec_base;
			ipc_gp <= next_ipc_gp;
			msw <= next_msw;
			gsw <= next_gsw;
			sem <= next_sem;
			lirq_prev <= lirq_in;
			acf_sys_prev <= {5'h1F, sysfail_n, acfail_n};
			rd_snap <= next_rd_snap;
			win_src <= next_win_src;
			avs_readdata <= next_readdata;
			avs_waitrequest <= next_waitrequest;
			irq <= next_irq;
			local_priority_level <= next_lpl;
			vme_irq_o <= 7'h00;
			vme_irq_oe <= next_intr_req;
			vme_iackout_n <= next_iackout_n;
			daisy_start_n <= next_daisy_n;
			vme_vec <= next_vec;
			ipc_rdata <= next_ipc_rdata;
		end
	end

	// ------------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	AST_LVL_MAX: assert property (local_priority_level != 3'd0 |->
		$past(status[next_win_src] && mask[next_win_src]) &&
		local_priority_level == $past(src_lvl[next_win_src]))
		else $error("priority output below winning level");
	AST_ZERO_IDLE: assert property (!(|(status & mask)) |=>
		local_priority_level == 3'd0)
		else $error("priority output not zero when idle");
	AST_ARB: assert property ((status[3] && mask[3] && vme_lvl[11:9] == 3'd7)
		|=> local_priority_level == 3'd7)
		else $error("level seven source not presented");
	AST_HND: assert property ((vme_irq_i[2] && !hnd_en[2]) |=>
		!status[2] || $past(status[2]))
		else $error("unhandled vme level set status");
	AST_SW: assert property ((ipc_req.wr && ipc_req.addr == `VMEIC_IPC_MSW
		&& ipc_req.wdata[0] && !msw[0]) |=> status[`VMEIC_ST_IPC] && msw[0])
		else $error("module switch set did not interrupt");
	AST_SEM: assert property ((ipc_req.rd && !ipc_req.wr
		&& ipc_req.addr == 4'h8) |=> sem[0] && ipc_rdata[0] == $past(sem[0]))
		else $error("semaphore test and set failed");
	AST_VEC: assert property (vme_vec.valid |->
		vme_vec.vector == $past(intr_vec) && !vme_irq_oe[$past(vme_ack_level)-1])
		else $error("acknowledge vector wrong");
	AST_DAISY: assert property (!sysctl |=> daisy_start_n)
		else $error("daisy chain driven while not system controller");
	AST_ACF: assert property ($fell(acfail_n) |=>
		status[`VMEIC_ST_ERR + `VMEIC_ERR_ACFAIL])
		else $error("acfail not latched");
	AST_BUS: assert property ((avs_read && avs_waitrequest) |=> !avs_waitrequest
		##1 (avs_waitrequest || !avs_read))
		else $error("waitrequest timing wrong");
endmodule
`default_nettype wire

// ### vmeic_defines.svh
// register offsets, field positions and reset values of the interrupt unit
// assumes byte addresses on a 32-bit avalon-mm slave port
`ifndef VMEIC_DEFINES_SVH
`define VMEIC_DEFINES_SVH
// ----------------------------------------------------------------------------
// local register byte offsets
// ----------------------------------------------------------------------------
`define VMEIC_OFS_CTRL 8'h00
`define VMEIC_OFS_HND_EN 8'h04
`define VMEIC_OFS_VME_LVL 8'h08
`define VMEIC_OFS_LIRQ_LVL 8'h0C
`define VMEIC_OFS_LIRQ_CFG 8'h10
`define VMEIC_OFS_GRP_LVL 8'h14
`define VMEIC_OFS_STATUS 8'h18
`define VMEIC_OFS_MASK 8'h1C
`define VMEIC_OFS_INTR 8'h20
`define VMEIC_OFS_ACK 8'h24
`define VMEIC_OFS_VEC_BASE 8'h28
`define VMEIC_OFS_IPC_GP 8'h2C
`define VMEIC_OFS_IPC_SW 8'h30
// ----------------------------------------------------------------------------
// status and mask layout, source numbering
// ----------------------------------------------------------------------------
`define VMEIC_ST_VME 0
`define VMEIC_ST_LOC 7
`define VMEIC_ST_ERR 14
`define VMEIC_ST_IPC 20
`define VMEIC_NSRC 28
`define VMEIC_ERR_ACFAIL 0
`define VMEIC_ERR_SYSFAIL 1
`define VMEIC_ERR_WPOST 2
`define VMEIC_ERR_DMA 3
`define VMEIC_ERR_ARB 4
`define VMEIC_ERR_INTR 5
// ----------------------------------------------------------------------------
// ipc port addresses and reset values
// ----------------------------------------------------------------------------
`define VMEIC_IPC_MSW 4'h4
`define VMEIC_IPC_GSW 4'h5
`define VMEIC_IPC_VER 4'h6
`define VMEIC_IPC_RSTHLT 4'h7
`define VMEIC_IPC_SEM 4'h8
`define VMEIC_RST_WORD 32'h0000_0000
`define VMEIC_RST_BYTE 8'h00
`endif

// ### vmeic_pkg.sv
// types shared by the interrupt and interprocessor unit
// assumes nothing beyond the defines header
package vmeic_pkg;
	// one access from the vmebus side to the interprocessor facility
	typedef struct packed {
		logic [3:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} vmeic_ipc_req_s;
	// answer of the vmebus interrupter to an acknowledge cycle
	typedef struct packed {
		logic valid;
		logic [7:0] vector;
	} vmeic_vec_s;
endpackage

// ### vmeic_far_end.sv
// far end model: vme side register accesses and acknowledge cycles
// assumes the bench calls its tasks and wires its pins to the unit
`timescale 1ns/1ns
`default_nettype none
module vmeic_far_end (
	input wire logic clk,
	output vmeic_pkg::vmeic_ipc_req_s ipc_req,
	input wire logic [7:0] ipc_rdata,
	output logic iack_n,
	output logic iackin_n,
	output logic [2:0] ack_level,
	input wire vmeic_pkg::vmeic_vec_s vme_vec,
	input wire logic iackout_n,
	input wire logic daisy_n
);
	import vmeic_pkg::*;
	// idle bus: no access, no acknowledge
	initial begin
		ipc_req = '0;
		iack_n = 1'b1;
		iackin_n = 1'b1;
		ack_level = 3'h0;
	end
	// one interprocessor access, answer taken a cycle later
	task automatic ipc(input logic [3:0] a, input logic w,
		input logic [7:0] d, output logic [7:0] r);
		@(posedge clk);
		ipc_req <= '{addr: a, wr: w, rd: !w, wdata: d};
		@(posedge clk);
		ipc_req <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
		@(posedge clk);
		r = ipc_rdata;
	endtask
	// acknowledge cycle of one level, bounded wait for the vector
	task automatic ack(input logic [2:0] l, output logic ok,
		output logic [7:0] v, output logic po, output logic ds);
		@(posedge clk);
		iack_n <= 1'b0;
		iackin_n <= 1'b0;
		ack_level <= l;
		ok = 1'b0;
		v = 8'h00;
		for (int i = 0; i < 8 && !ok; i++) begin
			@(posedge clk);
			ok = vme_vec.valid;
			v = vme_vec.vector;
			po = iackout_n;
			ds = daisy_n;
		end
		iack_n <= 1'b1;
		iackin_n <= 1'b1;
		ack_level <= ~l;
	endtask
endmodule
`default_nettype wire

// ### vmeic_unit_bench.sv
// self-checking bench of the interrupt and interprocessor unit
// assumes the far end model answers the vme side
`timescale 1ns/1ns
`default_nettype none
`include "vmeic_defines.svh"
`define CHK(g, e) begin \
	cmp_count++; \
	if ((g) !== (e)) begin \
		err_count++; \
		$display("ERROR t=%0t got=%h exp=%h", $time, g, e); \
	end \
end
module vmeic_unit_bench;
	import vmeic_pkg::*;
	logic clk;
	logic rst_n;
	logic [7:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic irq;
	logic [2:0] local_priority_level;
	logic [6:0] lirq_in;
	logic [6:0] far_irq;
	logic [6:0] vme_irq_oe;
	wire logic [6:0] vme_irq_i;
	logic iack_n;
	logic iackin_n;
	logic [2:0] ack_level;
	logic iackout_n;
	logic daisy_n;
	vmeic_vec_s vme_vec;
	logic acfail_n;
	logic sysfail_n;
	logic wpost_berr;
	logic dma_done;
	logic arb_timeout;
	vmeic_ipc_req_s ipc_req;
	logic [7:0] ipc_rdata;
	int err_count;
	int cmp_count;
	int lvl [`VMEIC_NSRC];
	logic [31:0] q;
	logic [31:0] cfg;
	logic [31:0] t;
	logic [7:0] b;
	logic ok;
	logic po;
	logic ds;
	// request lines: far modules and our own interrupter together
	assign vme_irq_i = far_irq | vme_irq_oe;
	vmeic_unit i_vmeic_unit (.clk(clk), .rst_n(rst_n),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hF), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .irq(irq),
		.local_priority_level(local_priority_level), .lirq_in(lirq_in),
		.vme_irq_i(vme_irq_i), .vme_irq_o(), .vme_irq_oe(vme_irq_oe),
		.vme_iack_n(iack_n), .vme_iackin_n(iackin_n),
		.vme_ack_level(ack_level), .vme_iackout_n(iackout_n),
		.daisy_start_n(daisy_n), .vme_vec(vme_vec), .acfail_n(acfail_n),
		.sysfail_n(sysfail_n), .wpost_berr(wpost_berr),
		.dma_done(dma_done), .arb_timeout(arb_timeout),
		.reset_cond(1'b0), .halt_cond(1'b1), .ipc_req(ipc_req),
		.ipc_rdata(ipc_rdata));
	vmeic_far_end i_vmeic_far_end (.clk(clk), .ipc_req(ipc_req),
		.ipc_rdata(ipc_rdata), .iack_n(iack_n), .iackin_n(iackin_n),
		.ack_level(ack_level), .vme_vec(vme_vec),
		.iackout_n(iackout_n), .daisy_n(daisy_n));
	// ------------------------------------------------------------------
	// model and bus tasks
	// ------------------------------------------------------------------
	// highest level among pending enabled sources, zero if none
	function automatic logic [2:0] prio(input logic [31:0] st);
		int m;
		m = 0;
		for (int i = 0; i < `VMEIC_NSRC; i++) begin
			if (st[i] && lvl[i] > m) begin
				m = lvl[i];
			end
		end
		return 3'(m);
	endfunction
	// one avalon access, held until waitrequest is seen low
	task automatic bus(input logic [7:0] a, input logic w,
		input logic [31:0] d);
		int n;
		@(posedge clk);
		avs_address <= a;
		avs_read <= !w;
		avs_write <= w;
		avs_writedata <= d;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		avs_writedata <= ~d;
		// no answer within the bound: count it and close the run
		if (avs_waitrequest !== 1'b0) begin
			err_count++;
			end_sim();
		end
	endtask
	task automatic chk_st(input logic [31:0] e);
		bus(`VMEIC_OFS_STATUS, 1'b0, 32'h0000_0000);
		`CHK(q, e)
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic end_sim();
		$display("errors %0d compares %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// ------------------------------------------------------------------
	// clock, watchdog and main sequence
	// ------------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		repeat (50000) @(posedge clk);
		err_count++;
		end_sim();
	end
	initial begin
		rst_n = 1'b0;
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0000_0000;
		lirq_in = 7'h7F; // idle for the active-low level default
		far_irq = 7'h00;
		acfail_n = 1'b1;
		sysfail_n = 1'b1;
		wpost_berr = 1'b0;
		dma_done = 1'b0;
		arb_timeout = 1'b0;
		err_count = 0;
		cmp_count = 0;
		void'($urandom(64192));
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		wt(1);
		`CHK({irq, local_priority_level}, 4'h0)
		chk_st(32'h0000_0000);
		bus(8'h3C, 1'b0, 32'h0000_0000);
		`CHK(q, 32'h0000_0000)
		i_vmeic_far_end.ipc(`VMEIC_IPC_VER, 1'b0, 8'h00, b);
		`CHK(b, 8'h01)
		i_vmeic_far_end.ipc(`VMEIC_IPC_RSTHLT, 1'b0, 8'h00, b);
		`CHK(b, 8'h02)
		// random levels for vme and local sources, fixed group levels
		cfg = $urandom & 32'h001F_FFFF;
		t = $urandom & 32'h001F_FFFF;
		for (int i = 0; i < 7; i++) begin
			lvl[i] = (cfg >> (3 * i)) & 7;
			lvl[7 + i] = (t >> (3 * i)) & 7;
		end
		for (int i = 14; i < 28; i++) begin
			lvl[i] = (i < 20) ? 3 : 5;
		end
		bus(`VMEIC_OFS_VME_LVL, 1'b1, cfg);
		bus(`VMEIC_OFS_LIRQ_LVL, 1'b1, t);
		bus(`VMEIC_OFS_GRP_LVL, 1'b1, 32'h0000_0053);
		bus(`VMEIC_OFS_MASK, 1'b1, 32'h0FFF_FFFF);
		// error and status events, masked then cleared
		acfail_n <= 1'b0;
		sysfail_n <= 1'b0;
		wpost_berr <= 1'b1;
		dma_done <= 1'b1;
		arb_timeout <= 1'b1;
		@(posedge clk);
		acfail_n <= 1'b1;
		sysfail_n <= 1'b1;
		wpost_berr <= 1'b0;
		dma_done <= 1'b0;
		arb_timeout <= 1'b0;
		wt(2);
		`CHK({irq, local_priority_level}, 4'hB)
		bus(`VMEIC_OFS_MASK, 1'b1, 32'h0FF0_3FFF);
		wt(2);
		`CHK({irq, local_priority_level}, 4'h0)
		bus(`VMEIC_OFS_MASK, 1'b1, 32'h0FFF_FFFF);
		chk_st(32'h0007_C000);
		chk_st(32'h0000_0000);
		wt(2);
		`CHK(irq, 1'b0)
		// local inputs: random sense, polarity and toggles
		for (int k = 0; k < 3; k++) begin
			cfg = $urandom & 32'h007F_7F7F;
			bus(`VMEIC_OFS_LIRQ_CFG, 1'b1, cfg);
			lirq_in <= ~cfg[14:8];
			wt(3);
			chk_st(32'h0000_0000);
			chk_st(32'h0000_0000);
			t = $urandom & 32'h0000_007F;
			lirq_in <= ~cfg[14:8] ^ t[6:0];
			wt(3);
			`CHK(local_priority_level, prio(t << 7))
			chk_st(t << 7);
			chk_st((t & ~cfg) << 7);
			lirq_in <= ~cfg[14:8];
			wt(3);
			chk_st((t & ~cfg) << 7);
			chk_st(32'h0000_0000);
		end
		// handled vme request lines
		t = $urandom & 32'h0000_007F;
		cfg = $urandom & 32'h0000_007F;
		bus(`VMEIC_OFS_HND_EN, 1'b1, t);
		far_irq <= cfg[6:0];
		wt(3);
		`CHK(local_priority_level, prio(t & cfg))
		chk_st(t & cfg);
		far_irq <= 7'h00;
		bus(`VMEIC_OFS_HND_EN, 1'b1, 32'h0000_0000);
		wt(3);
		chk_st(t & cfg);
		chk_st(32'h0000_0000);
		// interrupter: wrong level passes on, right level gets vector
		cfg = 1 + $urandom % 7;
		b = 8'($urandom);
		bus(`VMEIC_OFS_INTR, 1'b1, {16'h0000, b, 1'b0, 7'(1 << (cfg - 1))});
		wt(3);
		`CHK(vme_irq_oe, 7'(1 << (cfg - 1)))
		i_vmeic_far_end.ack(3'(cfg % 7 + 1), ok, t[7:0], po, ds);
		`CHK({ok, po, ds}, 3'h1)
		i_vmeic_far_end.ack(3'(cfg), ok, t[7:0], po, ds);
		`CHK({ok, po, t[7:0]}, {2'h3, b})
		wt(3);
		`CHK(vme_irq_oe, 7'h00)
		chk_st(32'h0008_0000);
		// system controller starts the daisy chain
		bus(`VMEIC_OFS_CTRL, 1'b1, 32'h0000_0001);
		i_vmeic_far_end.ack(3'h0, ok, t[7:0], po, ds);
		`CHK({ok, ds}, 2'h0)
		bus(`VMEIC_OFS_CTRL, 1'b1, 32'h0000_0000);
		// general purpose registers from the vme side
		for (int i = 0; i < 4; i++) begin
			cfg[8 * i +: 8] = 8'($urandom);
			i_vmeic_far_end.ipc(4'(i), 1'b1, cfg[8 * i +: 8], b);
		end
		for (int i = 0; i < 4; i++) begin
			i_vmeic_far_end.ipc(4'(i), 1'b0, 8'h00, b);
			`CHK(b, cfg[8 * i +: 8])
		end
		bus(`VMEIC_OFS_IPC_GP, 1'b0, 32'h0000_0000);
		`CHK(q, cfg)
		// module and global switches raise interrupts
		t = ($urandom & 32'h0000_00FF) | 32'h0000_0011;
		i_vmeic_far_end.ipc(`VMEIC_IPC_MSW, 1'b1, {4'h0, t[3:0]}, b);
		i_vmeic_far_end.ipc(`VMEIC_IPC_GSW, 1'b1, {4'h0, t[7:4]}, b);
		wt(2);
		`CHK(local_priority_level, 3'h5)
		bus(`VMEIC_OFS_IPC_SW, 1'b0, 32'h0000_0000);
		`CHK(q[7:0], t[7:0])
		chk_st(t << 20);
		bus(`VMEIC_OFS_IPC_SW, 1'b1, 32'h0000_00FF);
		bus(`VMEIC_OFS_IPC_SW, 1'b0, 32'h0000_0000);
		`CHK(q[7:0], 8'h00)
		// semaphore: test-and-set, cleared by a write
		i_vmeic_far_end.ipc(`VMEIC_IPC_SEM, 1'b0, 8'h00, b);
		`CHK(b, 8'h00)
		i_vmeic_far_end.ipc(`VMEIC_IPC_SEM, 1'b0, 8'h00, b);
		`CHK(b, 8'h01)
		i_vmeic_far_end.ipc(`VMEIC_IPC_SEM, 1'b1, 8'h00, b);
		i_vmeic_far_end.ipc(`VMEIC_IPC_SEM, 1'b0, 8'h00, b);
		`CHK(b, 8'h00)
		end_sim();
	end
endmodule
`default_nettype wire
